// [verilog/asr_defs.svh]
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// ************************************************************
// Clock
// ************************************************************
`define ASR_CLK_PERIOD_NS 10

// ************************************************************
// Timing figures and derived cycle counts
// ************************************************************
`define ASR_POR_TIME_US 500
`define ASR_POR_CYCLES ((`ASR_POR_TIME_US * 1000 + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_CONV_TIME_MS 147
`define ASR_CONV_CYCLES ((`ASR_CONV_TIME_MS * 1000000 + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_DET_WINDOW_US 400
`define ASR_DET_CYCLES ((`ASR_DET_WINDOW_US * 1000 + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_INT_OSC_PERIOD_NS 7148
`define ASR_OSC_CYCLES ((`ASR_INT_OSC_PERIOD_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_EXT_CONV_PERIODS 20510
`define ASR_SCK_DIV 8

// ************************************************************
// Counter widths
// ************************************************************
`define ASR_POR_CNT_W 16
`define ASR_CONV_CNT_W 24
`define ASR_DET_CNT_W 16
`define ASR_OSC_CNT_W 10
`define ASR_HALF_CNT_W 2
`define ASR_BIT_CNT_W 5

// ************************************************************
// Output word layout
// ************************************************************
`define ASR_WORD_BITS 32
`define ASR_CODE_BITS 30
`define ASR_PENDING_BIT 31
`define ASR_FILLER_BIT 30
`define ASR_SIGN_BIT 29
`define ASR_MSB_BIT 28
`define ASR_LSB_BIT 5
`define ASR_LAST_BIT_IDX 5'h1F
`define ASR_FILLER_VAL 1'h0

// ************************************************************
// Code clamps, in sub-LSB units, two's complement
// ************************************************************
`define ASR_CODE_OVER 30'h10000000
`define ASR_CODE_NEG_FS 30'h30000000
`define ASR_CODE_UNDER 30'h2FFFFFFF

`endif

// [verilog/asr_pkg.sv]
`include "asr_defs.svh"

package asr_pkg;

	typedef enum logic [3:0] {
		ST_POR = 4'h1,
		ST_CONVERT = 4'h2,
		ST_SLEEP = 4'h4,
		ST_OUTPUT = 4'h8
	} asr_state_e_t;

	typedef struct packed {
		asr_state_e_t state;
		logic [`ASR_POR_CNT_W-1:0] por_cnt;
		logic [`ASR_CONV_CNT_W-1:0] conv_cnt;
		logic [`ASR_DET_CNT_W-1:0] det_cnt;
		logic ext_present;
		logic [`ASR_OSC_CNT_W-1:0] osc_cnt;
		logic [`ASR_HALF_CNT_W-1:0] half_cnt;
		logic sck_gen;
		logic sck_ext;
		logic cs_q;
		logic sck_q;
		logic ccp_q;
		logic [`ASR_BIT_CNT_W-1:0] bit_cnt;
		logic [`ASR_WORD_BITS-1:0] shreg;
		logic sdo;
		logic sdo_oe;
		logic sck_oe;
	} asr_core_t;

	typedef struct packed {
		logic [2:0] stage1;
		logic [2:0] stage2;
	} asr_sync_t;

endpackage

// [verilog/asr_pins_if.sv]
`timescale 1ns/100ps

interface asr_pins_if;
	logic cs_n;
	logic sck;
	logic ccp;
	logic cs_n_s;
	logic sck_s;
	logic ccp_s;
	modport sync (input cs_n, input sck, input ccp,
		output cs_n_s, output sck_s, output ccp_s);
	modport core (output cs_n, output sck, output ccp,
		input cs_n_s, input sck_s, input ccp_s);
endinterface

// [verilog/asr_pin_sync.sv]
`timescale 1ns/100ps

module asr_pin_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Pin levels, raw and synchronised
	asr_pins_if.sync pins
);

	asr_pkg::asr_sync_t r;
	asr_pkg::asr_sync_t n;

	// Stage one feeds stage two only; nothing else looks at it.
	always_comb begin
		n = r;
		n.stage1 = {pins.ccp, pins.sck, pins.cs_n};
		n.stage2 = r.stage1;
	end

	// Chip select idles high so the core sees a deselected device in reset.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= {3'h1, 3'h1};
		end else begin
			r <= n;
		end
	end

	assign pins.cs_n_s = r.stage2[0];
	assign pins.sck_s = r.stage2[1];
	assign pins.ccp_s = r.stage2[2];

endmodule

// [verilog/adc_serial_result_sequencer.sv]
`timescale 1ns/100ps
`include "asr_defs.svh"

module adc_serial_result_sequencer #(
	parameter int POR_CYCLES = `ASR_POR_CYCLES,
	parameter int CONV_CYCLES = `ASR_CONV_CYCLES,
	parameter int DET_CYCLES = `ASR_DET_CYCLES,
	parameter int OSC_CYCLES = `ASR_OSC_CYCLES,
	parameter int EXT_CONV_PERIODS = `ASR_EXT_CONV_PERIODS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Serial interface pins
	input wire logic cs_n,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	output logic sdo_out,
	output logic sdo_oe,
	// Conversion clock pin
	input wire logic conversion_clock_pin,
	// Result from the digital filter, sub-LSB units
	input wire logic [`ASR_CODE_BITS-1:0] conv_code,
	// Status
	output logic conv_running,
	output logic conv_sleeping,
	output logic data_outputting,
	output logic ext_clock_present,
	output logic sck_external
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	generate
		if (POR_CYCLES < 1 || POR_CYCLES > (1 << `ASR_POR_CNT_W)) begin : g_chk_por
			$error("POR_CYCLES out of range");
		end
		if (CONV_CYCLES < 1 || CONV_CYCLES > (1 << `ASR_CONV_CNT_W)) begin : g_chk_conv
			$error("CONV_CYCLES out of range");
		end
		if (DET_CYCLES < 2 || DET_CYCLES > (1 << `ASR_DET_CNT_W)) begin : g_chk_det
			$error("DET_CYCLES out of range");
		end
		if (OSC_CYCLES < 1 || OSC_CYCLES > (1 << `ASR_OSC_CNT_W)) begin : g_chk_osc
			$error("OSC_CYCLES out of range");
		end
		if (EXT_CONV_PERIODS < 1
			|| EXT_CONV_PERIODS > (1 << `ASR_CONV_CNT_W)) begin : g_chk_ext
			$error("EXT_CONV_PERIODS out of range");
		end
	endgenerate

	localparam logic [`ASR_POR_CNT_W-1:0] POR_LAST =
		`ASR_POR_CNT_W'(POR_CYCLES - 1);
	localparam logic [`ASR_CONV_CNT_W-1:0] CONV_LAST =
		`ASR_CONV_CNT_W'(CONV_CYCLES - 1);
	localparam logic [`ASR_CONV_CNT_W-1:0] EXT_LAST =
		`ASR_CONV_CNT_W'(EXT_CONV_PERIODS - 1);
	localparam logic [`ASR_DET_CNT_W-1:0] DET_LAST =
		`ASR_DET_CNT_W'(DET_CYCLES - 1);
	localparam logic [`ASR_OSC_CNT_W-1:0] OSC_LAST =
		`ASR_OSC_CNT_W'(OSC_CYCLES - 1);
	localparam logic [`ASR_HALF_CNT_W-1:0] HALF_LAST =
		`ASR_HALF_CNT_W'(`ASR_SCK_DIV / 2 - 1);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	asr_pins_if pins ();

	assign pins.cs_n = cs_n;
	assign pins.sck = sck_in;
	assign pins.ccp = conversion_clock_pin;

	asr_pin_sync u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pins(pins.sync)
	);

	// ************************************************************
	// Result formatting
	// ************************************************************
	// The clamp is applied on the full code so that sub-LSBs follow it too.
	function automatic logic [`ASR_WORD_BITS-1:0] format_word(
		input logic [`ASR_CODE_BITS-1:0] code);
		logic [`ASR_CODE_BITS-1:0] c;
		c = code;
		if ($signed(code) >= $signed(`ASR_CODE_OVER)) begin
			c = `ASR_CODE_OVER;
		end else if ($signed(code) < $signed(`ASR_CODE_NEG_FS)) begin
			c = `ASR_CODE_UNDER;
		end
		// Inverting the top code bit gives a sign flag that is set
		// for non-negative values and leaves range in sign and MSB.
		format_word = {1'h0, `ASR_FILLER_VAL, ~c[`ASR_SIGN_BIT],
			c[`ASR_MSB_BIT:0]};
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	asr_pkg::asr_core_t r;
	asr_pkg::asr_core_t n;

	logic cs_low;
	logic cs_fall;
	logic cs_rise;
	logic ext_edge;
	logic int_tick;
	logic conv_tick;
	logic gen_run;
	logic half_done;
	logic int_rise;
	logic int_fall;
	logic ext_rise;
	logic ext_fall;
	logic sck_rise;
	logic sck_fall;
	logic conv_done;

	always_comb begin
		n = r;
		n.cs_q = pins.cs_n_s;
		n.sck_q = pins.sck_s;
		n.ccp_q = pins.ccp_s;
		cs_low = ~pins.cs_n_s;
		cs_fall = r.cs_q & ~pins.cs_n_s;
		cs_rise = ~r.cs_q & pins.cs_n_s;

		// ****************************************************
		// Conversion clock source
		// ****************************************************
		ext_edge = ~r.ccp_q & pins.ccp_s;
		if (ext_edge) begin
			n.det_cnt = '0;
			n.ext_present = 1'h1;
		end else if (r.det_cnt == DET_LAST) begin
			n.ext_present = 1'h0;
		end else begin
			n.det_cnt = r.det_cnt + 1'h1;
		end

		// The internal oscillator is held stopped while an external
		// clock is seen, so only one source ever ticks.
		int_tick = ~r.ext_present && (r.osc_cnt == OSC_LAST);
		if (r.ext_present || int_tick) begin
			n.osc_cnt = '0;
		end else begin
			n.osc_cnt = r.osc_cnt + 1'h1;
		end
		conv_tick = r.ext_present ? ext_edge : int_tick;

		// ****************************************************
		// Serial clock mode and internal serial clock
		// ****************************************************
		if (cs_fall) begin
			n.sck_ext = ~pins.sck_s;
		end

		gen_run = ~r.sck_ext && cs_low && !cs_fall
			&& (r.state == asr_pkg::ST_SLEEP
			|| r.state == asr_pkg::ST_OUTPUT);
		half_done = conv_tick && (r.half_cnt == HALF_LAST);
		if (!gen_run) begin
			n.half_cnt = '0;
			n.sck_gen = 1'h1;
		end else if (conv_tick) begin
			if (half_done) begin
				n.half_cnt = '0;
				n.sck_gen = ~r.sck_gen;
			end else begin
				n.half_cnt = r.half_cnt + 1'h1;
			end
		end
		int_rise = gen_run && half_done && !r.sck_gen;
		int_fall = gen_run && half_done && r.sck_gen;
		ext_rise = ~r.sck_q & pins.sck_s;
		ext_fall = r.sck_q & ~pins.sck_s;
		// Edges while deselected never reach the shift register.
		sck_rise = cs_low && (r.sck_ext ? ext_rise : int_rise);
		sck_fall = cs_low && (r.sck_ext ? ext_fall : int_fall);

		// ****************************************************
		// Conversion cycle
		// ****************************************************
		// A source switch mid-conversion only mixes the two counts,
		// which is why the end test is a bound rather than equality.
		if (r.ext_present) begin
			conv_done = ext_edge && (r.conv_cnt >= EXT_LAST);
		end else begin
			conv_done = (r.conv_cnt >= CONV_LAST);
		end

		case (r.state)
			asr_pkg::ST_POR: begin
				n.por_cnt = r.por_cnt + 1'h1;
				if (r.por_cnt == POR_LAST) begin
					n.state = asr_pkg::ST_CONVERT;
					n.conv_cnt = '0;
					n.sck_ext = ~pins.sck_s;
				end
			end
			asr_pkg::ST_CONVERT: begin
				if (conv_done) begin
					n.state = asr_pkg::ST_SLEEP;
					n.shreg = format_word(conv_code);
				end else if (!r.ext_present || ext_edge) begin
					n.conv_cnt = r.conv_cnt + 1'h1;
				end
			end
			asr_pkg::ST_SLEEP: begin
				// The result sits untouched until the first serial clock rise, from host or device.
				if (sck_rise) begin
					n.state = asr_pkg::ST_OUTPUT;
					n.bit_cnt = '0;
				end
			end
			asr_pkg::ST_OUTPUT: begin
				if (cs_rise) begin
					n.state = asr_pkg::ST_CONVERT;
					n.conv_cnt = '0;
				end else if (sck_fall) begin
					if (r.bit_cnt == `ASR_LAST_BIT_IDX) begin
						n.state = asr_pkg::ST_CONVERT;
						n.conv_cnt = '0;
					end else begin
						n.shreg = {r.shreg[`ASR_WORD_BITS-2:0], 1'h0};
						n.bit_cnt = r.bit_cnt + 1'h1;
					end
				end
			end
			default: begin
				n.state = asr_pkg::ST_POR;
				n.por_cnt = '0;
			end
		endcase

		// ****************************************************
		// Pin drivers
		// ****************************************************
		if (n.state == asr_pkg::ST_OUTPUT) begin
			n.sdo = n.shreg[`ASR_PENDING_BIT];
		end else begin
			// Pending flag: high while converting, low once asleep.
			n.sdo = (n.state != asr_pkg::ST_SLEEP);
		end
		n.sdo_oe = cs_low;
		n.sck_oe = cs_low && !cs_fall && ~n.sck_ext;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '{state: asr_pkg::ST_POR, por_cnt: '0, conv_cnt: '0,
				det_cnt: '0, ext_present: 1'h0, osc_cnt: '0,
				half_cnt: '0, sck_gen: 1'h1, sck_ext: 1'h0,
				cs_q: 1'h1, sck_q: 1'h0, ccp_q: 1'h0, bit_cnt: '0,
				shreg: '0, sdo: 1'h1, sdo_oe: 1'h0, sck_oe: 1'h0};
		end else begin
			r <= n;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign sdo_out = r.sdo;
	assign sdo_oe = r.sdo_oe;
	assign sck_out = r.sck_gen;
	assign sck_oe = r.sck_oe;
	assign conv_running = (r.state == asr_pkg::ST_CONVERT);
	assign conv_sleeping = (r.state == asr_pkg::ST_SLEEP);
	assign data_outputting = (r.state == asr_pkg::ST_OUTPUT);
	assign ext_clock_present = r.ext_present;
	assign sck_external = r.sck_ext;

endmodule

// [testbench/asr_seq_properties.sv]
`timescale 1ns/100ps
// ****************************************
// Pin-level checks of the result sequencer
// ****************************************
module asr_seq_properties #(
	parameter int CONV_CYCLES = 200
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Pins
	input wire logic cs_n,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic conversion_clock_pin,
	// Status
	input wire logic conv_running,
	input wire logic conv_sleeping,
	input wire logic data_outputting,
	input wire logic ext_clock_present
);
	int conv_len;
	logic conv_mixed;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// A conversion that saw the external clock is not timed, since a
	// source switch may stretch it.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			conv_len <= 0;
			conv_mixed <= 1'h0;
		end else begin
			conv_len <= conv_running ? conv_len + 1 : 0;
			conv_mixed <= conv_running & (conv_mixed | ext_clock_present);
		end
	end
	sequence s_cs_hi; cs_n [*5]; endsequence
	sequence s_abort; data_outputting ##1 cs_n [*5]; endsequence
	sequence s_cs_lo;
		(!cs_n && (conv_running || conv_sleeping || data_outputting)) [*5];
	endsequence
	property p_hiz; s_cs_hi |-> !sdo_oe; endproperty
	a_hiz: assert property (p_hiz) else $error("sdo driven");
	property p_drive; s_cs_lo |-> sdo_oe; endproperty
	a_drive: assert property (p_drive) else $error("sdo idle");
	property p_pend_hi; (conv_running && sdo_oe) [*2] |-> sdo_out; endproperty
	a_pend_hi: assert property (p_pend_hi) else $error("pend low");
	property p_pend_lo; (conv_sleeping && sdo_oe) [*2] |-> !sdo_out; endproperty
	a_pend_lo: assert property (p_pend_lo) else $error("pend high");
	property p_sleep; (conv_sleeping && cs_n) [*4] |=> conv_sleeping; endproperty
	a_sleep: assert property (p_sleep) else $error("left sleep");
	property p_abort; s_abort |-> ##[0:2] conv_running; endproperty
	a_abort: assert property (p_abort) else $error("no abort");
	property p_conv;
		$fell(conv_running) && !conv_mixed && !ext_clock_present |->
			conv_len >= CONV_CYCLES - 2 && conv_len <= CONV_CYCLES + 2;
	endproperty
	a_conv: assert property (p_conv) else $error("convert length");
	property p_det;
		$rose(conversion_clock_pin) |-> ##[1:5] ext_clock_present;
	endproperty
	a_det: assert property (p_det) else $error("clock unseen");
endmodule
bind adc_serial_result_sequencer asr_seq_properties chk_u (.*);

// [testbench/asr_host_model.sv]
`timescale 1ns/100ps
// *******************************
// Host end of the three-wire link
// *******************************
module asr_host_model (
	// Clock
	input wire logic sys_clk,
	// Link pins
	output logic cs_n,
	output logic sck_in,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic sdo_out,
	input wire logic sdo_oe
);
	logic host_sck = 1'h0;
	logic sdo_last = 1'h0;
	logic sdo_line;
	logic [31:0] cap;
	int n_rise;
	// A released data wire shows the inverse of its last level, so a stale
	// bit can never pass for a driven one.
	assign sck_in = sck_oe ? sck_out : host_sck;
	assign sdo_line = sdo_oe ? sdo_out : ~sdo_last;
	initial cs_n = 1'h1;
	always @(posedge sys_clk) if (sdo_oe) sdo_last <= sdo_out;
	// The device returns its own clock high after the last bit, which gives
	// one more rise than the 32 bits of the word, so only 32 are taken.
	always @(posedge sck_in) begin
		if (!cs_n && n_rise < 32) begin
			cap <= {cap[30:0], sdo_line};
			n_rise <= n_rise + 1;
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// A low clock at the select fall asks for host clocking; high lets the
	// device clock itself.
	task automatic xfer(input int nbits, input logic int_mode);
		int i;
		host_sck = int_mode;
		n_rise = 0;
		step(8);
		cs_n = 1'h0;
		for (i = 0; int_mode && i < 3000 && n_rise < 32; i++) step(1);
		for (i = 0; !int_mode && i < nbits; i++) begin
			step(8);
			host_sck = 1'h1;
			step(8);
			host_sck = 1'h0;
		end
		step(8);
	endtask
	task automatic release_cs();
		cs_n = 1'h1;
		step(6);
	endtask
endmodule

// [testbench/adc_serial_result_sequencer_tb.sv]
`timescale 1ns/100ps
// ***************************************
// Self-checking bench of the result sequencer
// ***************************************
module adc_serial_result_sequencer_tb;
	localparam int DET_T = 50;
	localparam logic [29:0] TBL [6] = '{30'h00000000, 30'h3FFFFFFF,
		30'h0FFFFFFF, 30'h12345678, 30'h30000000, 30'h20000000};
	logic sys_clk = 1'h0;
	logic rst, conversion_clock_pin, ext_en, cs_n, sck_in, sck_out, sck_oe;
	logic sdo_out, sdo_oe, conv_running, conv_sleeping, data_outputting;
	logic ext_clock_present, sck_external;
	logic [29:0] conv_code;
	logic [31:0] exp_q [$];
	int n_fail, compares, cycles, seed, k, n;
	adc_serial_result_sequencer #(.POR_CYCLES(20), .CONV_CYCLES(200),
		.DET_CYCLES(DET_T), .OSC_CYCLES(3), .EXT_CONV_PERIODS(10)) dut_u (.*);
	asr_host_model host_u (.*);
	always #5 sys_clk = ~sys_clk;
	// Grounded for the internal oscillator, else a square wave of twenty
	// system clocks, fast enough to count as an external source.
	always begin
		host_u.step(10);
		conversion_clock_pin <= ext_en ? ~conversion_clock_pin : 1'h0;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_fail++;
			complete_run();
		end
	end
	function automatic logic [31:0] model_word(input logic [29:0] c);
		int v;
		v = $signed({{2{c[29]}}, c});
		v = (v >= 32'sh10000000) ? 32'sh10000000 : v;
		v = (v < -32'sh10000000) ? -32'sh10000001 : v;
		return {2'h0, ~v[29], v[28:0]};
	endfunction
	task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want) begin
			n_fail++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask
	task automatic chk_bit(input logic got, input logic want);
		chk_word({31'h0, got}, {31'h0, want});
	endtask
	task automatic wait_sleep(input int lim);
		int i;
		for (i = 0; i < lim && conv_sleeping !== 1'h1; i++) host_u.step(1);
	endtask
	task automatic complete_run();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		seed = 32;
		rst = 1'h1;
		ext_en = 1'h0;
		conversion_clock_pin = 1'h0;
		conv_code = 30'h0;
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'h0;
		for (k = 0; k < 9; k++) begin
			conv_code = (k < 6) ? TBL[k] : 30'($random(seed));
			exp_q.push_back(model_word(conv_code));
			wait_sleep(600);
			chk_bit(conv_sleeping, 1'h1);
			host_u.xfer(32, 1'h0);
			chk_bit(host_u.sdo_line, 1'h1);
			chk_bit(sck_external, 1'h1);
			chk_word(host_u.cap, exp_q.pop_front());
			host_u.release_cs();
			chk_bit(sdo_oe, 1'h0);
		end
		$display("external clock reads done");
		wait_sleep(600);
		host_u.xfer(5, 1'h0);
		chk_bit(data_outputting, 1'h1);
		host_u.release_cs();
		chk_bit(conv_running, 1'h1);
		$display("abort done");
		conv_code = 30'($random(seed));
		exp_q.push_back(model_word(conv_code));
		wait_sleep(600);
		host_u.xfer(32, 1'h1);
		chk_bit(sck_external, 1'h0);
		chk_word(host_u.cap, exp_q.pop_front());
		host_u.release_cs();
		$display("internal clock read done");
		ext_en = 1'h1;
		conv_code = 30'($random(seed));
		exp_q.push_back(model_word(conv_code));
		host_u.step(40);
		chk_bit(ext_clock_present, 1'h1);
		wait_sleep(1000);
		host_u.xfer(32, 1'h0);
		chk_word(host_u.cap, exp_q.pop_front());
		host_u.release_cs();
		for (n = 0; n < 999 && conv_running === 1'h1; n++) host_u.step(1);
		chk_bit(n >= 160 && n <= 205, 1'h1);
		ext_en = 1'h0;
		host_u.step(DET_T + 30);
		chk_bit(ext_clock_present, 1'h0);
		$display("conversion clock detection done");
		complete_run();
	end
endmodule
